// [logic/elapsed_time_counter.sv]
`timescale 1ns/1ps
// Overview of operation
// - 44-bit up counter advances one 244us step per tick while enabled.
// - Running count and user copy; transfer enable governs copy refresh.
// - Supply-time mode counts only on the chosen supply source.
// - Event mode counts while event input sits at its selectable level.
// - During power-fail, event mode ignores the event input and stops counting.
// - Match value equal to whole seconds sets the match flag.
// - Match flag with its enable drives interrupt output low.
// - Periodic flag only runs with a non-zero rate select.
// - Periodic flag sets at the selected rate, stays until written 0.
// - Clearing periodic flag leaves the shared prescaler untouched.
// - Counting continues; periodic flag sets again at each later period boundary.
// - Periodic flag with its enable pulls interrupt output low.
// - Periodic rate spans every 244us to once per 24.27 days.
// - Match, periodic flag and interrupt work on either supply.
// - Writing count bytes shifts periodic timing through the shared chain.
// - Square output has its own prescaler, immune to count writes.
// - Whole seconds sit in four bytes, low first, at 02h to 05h.
// - Fraction at 00h/01h; low nibble in 00h[7:4], 00h[0] square sync.
// - User copy refreshes each tick while transfer is enabled, so host access never stalls counting.
// - Oscillator disabled stops ticks, freezes the count and prescalers, and sets the stop flag.
// - Reset loads defined contents with the oscillator off; host initialises before use.
// - Chip enable with write low writes, with output enable low reads.
// - Two-bit config: always, event and good power, primary, battery.
// - Event polarity 1 counts on high input, 0 on low input.
module elapsed_time_counter
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Oscillator, supply state and event input pins
  input wire logic osc_in,
  input wire logic on_battery,
  input wire logic power_fail,
  input wire logic event_input,
  // Byte-wide host bus
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [3:0] addr_pins,
  input wire logic [7:0] data_pins_in,
  output logic [7:0] data_pins_out,
  output logic data_pins_oe,
  // Interrupt, open drain
  output logic irq_n_out,
  output logic irq_n_oe,
  // Square wave
  output logic square_out,
  output logic square_oe
);
  import etc_pkg::*;

  // Two-flop synchronisers for every pin
  localparam int SYNC_W = 22;
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  assign pin_raw = {osc_in, on_battery, power_fail, event_input, ce_n, oe_n, we_n, addr_pins, data_pins_in,
                    3'h0};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // Strobes start idle, else a phantom write follows reset
      sync_a <= PIN_SYNC_RESET;
      sync_b <= PIN_SYNC_RESET;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  logic osc_s, batt_s, fail_s, event_s, ce_n_s, oe_n_s, we_n_s;
  logic [3:0] addr_s;
  logic [7:0] data_s;
  assign osc_s = sync_b[21];
  assign batt_s = sync_b[20];
  assign fail_s = sync_b[19];
  assign event_s = sync_b[18];
  assign ce_n_s = sync_b[17];
  assign oe_n_s = sync_b[16];
  assign we_n_s = sync_b[15];
  assign addr_s = sync_b[14:11];
  assign data_s = sync_b[10:3];

  // Registers
  logic [7:0] control;
  logic [7:0] rate;
  logic [31:0] match;
  logic square_sync;
  logic [COUNT_W-1:0] running;
  logic [COUNT_W-1:0] user_copy;
  logic copy_dirty;
  logic osc_stop_flag;
  logic update_in_progress_flag;
  logic periodic_flag;
  logic match_flag;

  logic copy_transfer_enable, oscillator_enable, event_polarity, square_out_enable;
  logic periodic_irq_enable, match_irq_enable;
  logic [3:0] periodic_rate_select;
  logic [3:0] square_rate_select;
  count_cfg_t count_cfg;
  assign copy_transfer_enable = control[CTL_COPY_EN];
  assign oscillator_enable = control[CTL_OSC_EN];
  assign count_cfg = count_cfg_t'({control[CTL_CFG_HI], control[CTL_CFG_LO]});
  assign event_polarity = control[CTL_EVENT_POL];
  assign square_out_enable = control[CTL_SQUARE_EN];
  assign periodic_irq_enable = control[CTL_PERIODIC_IRQ];
  assign match_irq_enable = control[CTL_MATCH_IRQ];
  assign periodic_rate_select = rate[7:4];
  assign square_rate_select = rate[3:0];

  // Host bus: capture while the write strobe is low, commit on its release
  logic wr_active, wr_active_d, wr_commit;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  assign wr_active = !ce_n_s && !we_n_s && !fail_s;
  assign wr_commit = wr_active_d && !wr_active;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_active_d <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 8'h00;
    end else begin
      wr_active_d <= wr_active;
      if (wr_active) begin
        wr_addr <= addr_s;
        wr_data <= data_s;
      end
    end
  end

  logic wr_control, wr_rate, wr_flags, wr_count;
  assign wr_control = wr_commit && (wr_addr == ADDR_PRIMARY_CONTROL);
  assign wr_rate = wr_commit && (wr_addr == ADDR_RATE_CONTROL);
  assign wr_flags = wr_commit && (wr_addr == ADDR_EVENT_FLAGS);
  assign wr_count = wr_commit && (wr_addr <= ADDR_SECONDS_BYTE3);

  // contents hold their reset values until the host writes them
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      control <= CONTROL_RESET;
      rate <= RATE_RESET;
      match <= MATCH_RESET;
      square_sync <= 1'b0;
    end else begin
      if (wr_control) begin
        control <= wr_data;
      end
      if (wr_rate) begin
        rate <= wr_data;
      end
      if (wr_commit && wr_addr >= ADDR_MATCH_BYTE0 && wr_addr <= ADDR_MATCH_BYTE3) begin
        match[8*(wr_addr - ADDR_MATCH_BYTE0) +: 8] <= wr_data;
      end
      if (wr_commit && wr_addr == ADDR_FRACTION_LOW) begin
        square_sync <= wr_data[SQUARE_SYNC_BIT];
      end
    end
  end

  // Oscillator edge and divide-by-eight tick
  logic osc_d, osc_rise, tick;
  logic [2:0] osc_div;
  assign osc_rise = osc_s && !osc_d && oscillator_enable;
  assign tick = osc_rise && (osc_div == OSC_DIV_LAST);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      osc_d <= 1'b0;
      osc_div <= 3'h0;
    end else begin
      osc_d <= osc_s;
      if (osc_rise) begin
        osc_div <= osc_div + 3'h1;
      end
    end
  end

  // Counting condition
  logic count_en;
  always_comb begin
    count_en = 1'b0;
    unique case (count_cfg)
      CFG_ALWAYS: count_en = 1'b1;
      CFG_EVENT: count_en = (event_s == event_polarity) && !fail_s;
      CFG_PRIMARY: count_en = !batt_s;
      CFG_BATTERY: count_en = batt_s;
    endcase
  end

  // Running count and user copy
  logic [COUNT_W-1:0] base_count;
  logic [COUNT_W-1:0] next_running;
  logic advance;
  assign advance = tick && count_en;
  // Pending host write is loaded on the first tick after transfer enable returns
  assign base_count = (copy_transfer_enable && copy_dirty) ? user_copy : running;
  assign next_running = advance ? base_count + 44'h001 : base_count;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      running <= COUNT_RESET;
    end else if (tick) begin
      running <= next_running;
    end
  end

  // copy refresh gated by transfer enable
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      user_copy <= COUNT_RESET;
      copy_dirty <= 1'b0;
    end else if (wr_count) begin
      copy_dirty <= 1'b1;
      if (wr_addr == ADDR_FRACTION_LOW) begin
        user_copy[3:0] <= wr_data[7:FRAC_LOW_NIBBLE];
      end else begin
        user_copy[8*(wr_addr - ADDR_FRACTION_HIGH) + 4 +: 8] <= wr_data;
      end
    end else if (tick && copy_transfer_enable) begin
      user_copy <= next_running;
      copy_dirty <= 1'b0;
    end
  end

  // Update window: the oscillator edge that will cause the next transfer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      update_in_progress_flag <= 1'b0;
    end else begin
      update_in_progress_flag <= oscillator_enable && (osc_div == OSC_DIV_LAST);
    end
  end

  // Periodic flag: boundaries of the shared running count
  logic [COUNT_W-1:0] period_mask;
  logic periodic_hit;
  assign period_mask = (44'h001 << periodic_shift(periodic_rate_select)) - 44'h001;
  assign periodic_hit = advance && (periodic_rate_select != 4'h0) && ((next_running & period_mask) == '0);

  // Match compare on whole seconds, flag on becoming equal
  logic seconds_equal, seconds_equal_d, match_hit;
  assign seconds_equal = (running[COUNT_W-1:FRACTION_W] == match);
  assign match_hit = seconds_equal && !seconds_equal_d;

  logic clear_periodic, clear_match, clear_osc_stop;
  assign clear_periodic = wr_flags && !wr_data[FLAG_PERIODIC];
  assign clear_match = wr_flags && !wr_data[FLAG_MATCH];
  assign clear_osc_stop = wr_flags && !wr_data[FLAG_OSC_STOP];

  // Flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      seconds_equal_d <= 1'b1;
      periodic_flag <= 1'b0;
      match_flag <= 1'b0;
      osc_stop_flag <= 1'b1;
    end else begin
      seconds_equal_d <= seconds_equal;
      if (periodic_hit) begin
        periodic_flag <= 1'b1;
      end else if (clear_periodic) begin
        periodic_flag <= 1'b0;
      end
      if (match_hit) begin
        match_flag <= 1'b1;
      end else if (clear_match) begin
        match_flag <= 1'b0;
      end
      if (!oscillator_enable) begin
        osc_stop_flag <= 1'b1;
      end else if (clear_osc_stop) begin
        osc_stop_flag <= 1'b0;
      end
    end
  end

  logic irq_active;
  assign irq_active = (match_irq_enable && match_flag) || (periodic_irq_enable && periodic_flag);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_n_oe <= 1'b0;
    end else begin
      irq_n_oe <= irq_active;
    end
  end
  assign irq_n_out = 1'b0;

  logic [SQUARE_W-1:0] square_div;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      square_div <= '0;
    end else if (square_sync) begin
      // Sync holds only the sub-4096 Hz stages; faster ones keep running
      square_div[SQUARE_W-1:SQUARE_SYNC_LOW] <= '0;
      if (osc_rise) begin
        square_div[SQUARE_SYNC_LOW-1:0] <= square_div[SQUARE_SYNC_LOW-1:0] + 3'h1;
      end
    end else if (osc_rise) begin
      square_div <= square_div + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      square_out <= 1'b0;
      square_oe <= 1'b0;
    end else begin
      square_oe <= !fail_s;
      if (!square_out_enable || !oscillator_enable) begin
        square_out <= 1'b0;
      end else if (square_rate_select == 4'h0) begin
        square_out <= osc_s;
      end else begin
        square_out <= square_div[square_rate_select];
      end
    end
  end

  // Read mux, registered onto the data pins
  logic [7:0] read_data;
  always_comb begin
    read_data = 8'h00;
    unique case (addr_s)
      ADDR_FRACTION_LOW: read_data = {user_copy[3:0], 3'h0, square_sync};
      ADDR_FRACTION_HIGH: read_data = user_copy[11:4];
      ADDR_SECONDS_BYTE0: read_data = user_copy[19:12];
      ADDR_SECONDS_BYTE1: read_data = user_copy[27:20];
      ADDR_SECONDS_BYTE2: read_data = user_copy[35:28];
      ADDR_SECONDS_BYTE3: read_data = user_copy[43:36];
      ADDR_MATCH_BYTE0: read_data = match[7:0];
      ADDR_MATCH_BYTE1: read_data = match[15:8];
      ADDR_MATCH_BYTE2: read_data = match[23:16];
      ADDR_MATCH_BYTE3: read_data = match[31:24];
      ADDR_PRIMARY_CONTROL: read_data = control;
      ADDR_RATE_CONTROL: read_data = rate;
      ADDR_EVENT_FLAGS: read_data = {osc_stop_flag, update_in_progress_flag, 4'h0, periodic_flag, match_flag};
      default: read_data = 8'h00;
    endcase
  end

  // Power-fail floats the data pins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_pins_out <= 8'h00;
      data_pins_oe <= 1'b0;
    end else begin
      data_pins_out <= read_data;
      data_pins_oe <= !ce_n_s && !oe_n_s && we_n_s && !fail_s;
    end
  end

endmodule

// [logic/etc_pkg.sv]
package etc_pkg;

  // Register addresses on the byte-wide bus
  localparam logic [3:0] ADDR_FRACTION_LOW = 4'h0;
  localparam logic [3:0] ADDR_FRACTION_HIGH = 4'h1;
  localparam logic [3:0] ADDR_SECONDS_BYTE0 = 4'h2;
  localparam logic [3:0] ADDR_SECONDS_BYTE1 = 4'h3;
  localparam logic [3:0] ADDR_SECONDS_BYTE2 = 4'h4;
  localparam logic [3:0] ADDR_SECONDS_BYTE3 = 4'h5;
  localparam logic [3:0] ADDR_MATCH_BYTE0 = 4'h6;
  localparam logic [3:0] ADDR_MATCH_BYTE1 = 4'h7;
  localparam logic [3:0] ADDR_MATCH_BYTE2 = 4'h8;
  localparam logic [3:0] ADDR_MATCH_BYTE3 = 4'h9;
  localparam logic [3:0] ADDR_PRIMARY_CONTROL = 4'hA;
  localparam logic [3:0] ADDR_RATE_CONTROL = 4'hB;
  localparam logic [3:0] ADDR_EVENT_FLAGS = 4'hC;

  // Primary control bit positions
  localparam int CTL_COPY_EN = 7;
  localparam int CTL_OSC_EN = 6;
  localparam int CTL_CFG_HI = 5;
  localparam int CTL_CFG_LO = 4;
  localparam int CTL_EVENT_POL = 3;
  localparam int CTL_SQUARE_EN = 2;
  localparam int CTL_PERIODIC_IRQ = 1;
  localparam int CTL_MATCH_IRQ = 0;

  // Event flag bit positions
  localparam int FLAG_OSC_STOP = 7;
  localparam int FLAG_UPDATE = 6;
  localparam int FLAG_PERIODIC = 1;
  localparam int FLAG_MATCH = 0;

  // Fraction low byte layout
  localparam int FRAC_LOW_NIBBLE = 4;
  localparam int SQUARE_SYNC_BIT = 0;

  // Counter geometry
  localparam int FRACTION_W = 12;
  localparam int SECONDS_W = 32;
  localparam int COUNT_W = 44;

  // Oscillator to count-tick divider (32.768 kHz / 8 = 4.096 kHz)
  localparam int OSC_DIV_RATIO = 8;
  localparam logic [2:0] OSC_DIV_LAST = 3'(OSC_DIV_RATIO - 1);
  localparam real TICK_PERIOD_US = 244.0;

  // Square prescaler: bits at or above this index are below 4096 Hz
  localparam int SQUARE_W = 16;
  localparam int SQUARE_SYNC_LOW = 3;

  // Values after reset
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 44'h000_0000_0000;
  localparam logic [31:0] MATCH_RESET = 32'h0000_0000;
  // Pin synchroniser reset: bus strobes idle high, all else low
  localparam logic [21:0] PIN_SYNC_RESET = 22'h03_8000;

  typedef enum logic [1:0] {
    CFG_ALWAYS = 2'b00,
    CFG_EVENT = 2'b01,
    CFG_PRIMARY = 2'b10,
    CFG_BATTERY = 2'b11
  } count_cfg_t;

  // Count bits below the periodic boundary, per rate select
  function automatic logic [5:0] periodic_shift(input logic [3:0] sel);
    logic [5:0] k;
    k = 6'h00;
    case (sel)
      4'h1: k = 6'h00;
      4'h2: k = 6'h01;
      4'h3: k = 6'h02;
      4'h4: k = 6'h03;
      4'h5: k = 6'h04;
      4'h6: k = 6'h05;
      4'h7: k = 6'h09;
      4'h8: k = 6'h0A;
      4'h9: k = 6'h0B;
      4'hA: k = 6'h0C;
      4'hB: k = 6'h12;
      4'hC: k = 6'h18;
      4'hD: k = 6'h1C;
      4'hE: k = 6'h1F;
      4'hF: k = 6'h21;
      default: k = 6'h00;
    endcase
    return k;
  endfunction

endpackage

// [test/elapsed_time_counter_tb_top.sv]
`timescale 1ns/1ps
module elapsed_time_counter_tb_top;
  import etc_pkg::*;
  logic clk_sys, nrst, osc_in, on_battery, power_fail, event_input, pl, pf_w;
  logic ce_n, oe_n, we_n, data_pins_oe, irq_n_out, irq_n_oe, square_out, square_oe;
  logic [1:0] cf;
  logic [3:0] addr_pins, st;
  logic [7:0] data_pins_in, data_pins_out;
  logic [31:0] secs, mt, rs;
  logic [5:0] rows [10] = '{6'h00, 6'h1C, 6'h18, 6'h10, 6'h14, 6'h1E, 6'h20, 6'h21, 6'h31, 6'h30};
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int t1, t2;
  elapsed_time_counter uut (.clk_sys(clk_sys), .nrst(nrst), .osc_in(osc_in), .on_battery(on_battery),
    .power_fail(power_fail), .event_input(event_input), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr_pins(addr_pins), .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .square_out(square_out), .square_oe(square_oe));
  etc_host host (.clk_sys(clk_sys), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr_pins),
    .dout(data_pins_in), .din(data_pins_out), .doe(data_pins_oe));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Fast stand-in oscillator, eight clocks a period, keeps ticks short
  initial begin
    osc_in = 1'b0;
    #7;
    forever #20 osc_in = ~osc_in;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic run_exp(input logic [5:0] r);
    case (r[5:4])
      CFG_ALWAYS: return 1'b1;
      CFG_EVENT: return (r[3] == r[2]) && !r[1];
      CFG_PRIMARY: return !r[0];
      default: return r[0];
    endcase
  endfunction
  function automatic int gap(input int k);
    return (8 * OSC_DIV_RATIO) << k;
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, lo);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk8(v & m, e);
  endtask
  task automatic clr();
    host.wr(ADDR_EVENT_FLAGS, 8'h00);
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    while (irq_n_oe !== 1'b1 && n < 2500) begin
      @(negedge clk_sys);
      n++;
    end
    t = cycles;
    chk8({7'h0, irq_n_oe}, 8'h01);
  endtask
  // Nibble advance of the fraction over ten ticks
  task automatic frac_step(input logic f, output logic [3:0] d);
    logic [7:0] a, b;
    host.rd(ADDR_FRACTION_LOW, a);
    power_fail = f;
    repeat (640) @(negedge clk_sys);
    power_fail = 1'b0;
    host.rd(ADDR_FRACTION_LOW, b);
    d = b[7:4] - a[7:4];
  endtask
  task automatic rd_secs(output logic [31:0] s);
    logic [7:0] lo, b;
    s = 32'h0000_0000;
    do begin
      host.rd(ADDR_SECONDS_BYTE0, lo);
      for (int i = 1; i < 4; i++) begin
        host.rd(4'(ADDR_SECONDS_BYTE0 + i), b);
        s[8*i +: 8] = b;
      end
      host.rd(ADDR_SECONDS_BYTE0, b);
    end while (b !== lo);
    s[7:0] = lo;
  endtask
  // Square wave rising edge, cycle stamp
  task automatic sq_rise(output int t);
    @(posedge square_out);
    @(negedge clk_sys);
    t = cycles;
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    on_battery = 1'b0;
    power_fail = 1'b0;
    event_input = 1'b0;
    secs = lfsr(32'h51CC6113);
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdc(ADDR_PRIMARY_CONTROL, 8'hFF, CONTROL_RESET);
    rdc(ADDR_RATE_CONTROL, 8'hFF, RATE_RESET);
    rdc(ADDR_EVENT_FLAGS, 8'h80, 8'h80);
    rdc(4'hD, 8'hFF, 8'h00);
    host.wr(4'hE, 8'h5A);
    rdc(4'hE, 8'hFF, 8'h00);
    $display("TEST reset done");
    secs = lfsr(secs);
    mt = secs + 32'h1;
    host.wr(ADDR_PRIMARY_CONTROL, 8'h40);
    host.wr(ADDR_FRACTION_LOW, 8'h00);
    host.wr(ADDR_FRACTION_HIGH, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      host.wr(4'(ADDR_SECONDS_BYTE0 + i), secs[8*i +: 8]);
      host.wr(4'(ADDR_MATCH_BYTE0 + i), mt[8*i +: 8]);
    end
    for (int i = 0; i < 4; i++) begin
      rdc(4'(ADDR_MATCH_BYTE0 + i), 8'hFF, mt[8*i +: 8]);
    end
    clr();
    host.wr(ADDR_PRIMARY_CONTROL, 8'hC1);
    wait_irq(t1);
    host.wr(ADDR_PRIMARY_CONTROL, 8'h41);
    for (int i = 0; i < 4; i++) begin
      rdc(4'(ADDR_SECONDS_BYTE0 + i), 8'hFF, mt[8*i +: 8]);
    end
    rdc(ADDR_EVENT_FLAGS, 8'h01, 8'h01);
    $display("TEST count and match done");
    host.wr(ADDR_PRIMARY_CONTROL, 8'hC2);
    rd_secs(rs);
    for (int i = 0; i < 4; i++) begin
      chk8(rs[8*i +: 8], mt[8*i +: 8]);
    end
    on_battery = 1'b1;
    host.wr(ADDR_RATE_CONTROL, 8'h00);
    clr();
    repeat (700) @(negedge clk_sys);
    chk8({7'h0, irq_n_oe}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      host.wr(ADDR_RATE_CONTROL, 8'((k + 1) << 4));
      clr();
      wait_irq(t1);
      clr();
      chk8({7'h0, irq_n_oe}, 8'h00);
      wait_irq(t1);
      clr();
      wait_irq(t2);
      chk_rng(t2 - t1, gap(k) - 2, gap(k) + 2);
    end
    $display("TEST periodic done");
    host.wr(ADDR_RATE_CONTROL, 8'h00);
    for (int i = 0; i < 10; i++) begin
      {cf, pl, event_input, pf_w, on_battery} = rows[i];
      host.wr(ADDR_PRIMARY_CONTROL, {2'b11, cf, pl, 3'b000});
      frac_step(pf_w, st);
      chk8({7'h0, st > 4'h4}, {7'h0, run_exp(rows[i])});
    end
    $display("TEST modes done");
    host.wr(ADDR_RATE_CONTROL, 8'h03);
    host.wr(ADDR_PRIMARY_CONTROL, 8'hC4);
    sq_rise(t1);
    sq_rise(t1);
    chk8({7'h0, square_oe}, 8'h01);
    host.wr(ADDR_SECONDS_BYTE0, rs[7:0]);
    sq_rise(t2);
    chk_rng(t2 - t1, 126, 130);
    $display("TEST square done");
    host.wr(ADDR_PRIMARY_CONTROL, 8'h80);
    frac_step(1'b0, st);
    chk8({4'h0, st}, 8'h00);
    rdc(ADDR_EVENT_FLAGS, 8'h80, 8'h80);
    $display("TEST oscillator stop done");
    wrap_up();
  end
endmodule

// [test/etc_host.sv]
`timescale 1ns/1ps
module etc_host (
  // Clock
  input wire logic clk_sys,
  // Strobes, address and write data
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [3:0] addr,
  output logic [7:0] dout,
  // Read data from device
  input wire logic [7:0] din,
  input wire logic doe
);
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 4'h0;
    dout = 8'hA5;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    dout = d;
    ce_n = 1'b0;
    we_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    ce_n = 1'b1;
    we_n = 1'b1;
    // Released data shows the inverse so stale values never match
    dout = ~d;
    repeat (5) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    d = doe ? din : 8'hXX;
    ce_n = 1'b1;
    oe_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule

// [test/etc_monitor.sv]
`timescale 1ns/1ps
module etc_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Pin inputs
  input wire logic osc_in,
  input wire logic on_battery,
  input wire logic power_fail,
  input wire logic event_input,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [3:0] addr_pins,
  input wire logic [7:0] data_pins_in,
  // Pin outputs
  input wire logic [7:0] data_pins_out,
  input wire logic data_pins_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic square_out,
  input wire logic square_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic rd_sel;
  logic [7:0] wr_age;
  assign rd_sel = !ce_n && !oe_n && we_n && !power_fail;
  // Cycles since a write strobe, saturating
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_age <= 8'hFF;
    end else if (!ce_n && !we_n) begin
      wr_age <= 8'h00;
    end else if (wr_age != 8'hFF) begin
      wr_age <= wr_age + 8'h01;
    end
  end
  sequence rd_held;
    rd_sel [*4];
  endsequence
  sequence wr_held;
    (!ce_n && !we_n) [*4];
  endsequence
  read_drive_a: assert property (rd_held |-> data_pins_oe)
    else $error("read cycle left data pins undriven");
  drive_cause_a: assert property (data_pins_oe |-> $past(rd_sel, 2) || $past(rd_sel, 3) || $past(rd_sel, 4))
    else $error("data pins driven without a read");
  write_quiet_a: assert property (wr_held |-> !data_pins_oe)
    else $error("data pins driven during write");
  deselect_quiet_a: assert property (ce_n [*4] |-> !data_pins_oe)
    else $error("data pins driven while deselected");
  oe_quiet_a: assert property (oe_n [*4] |-> !data_pins_oe)
    else $error("data pins driven with output enable high");
  fail_float_a: assert property (power_fail [*4] |-> !data_pins_oe && !square_oe)
    else $error("pins driven in power fail");
  unmapped_zero_a: assert property ((rd_sel && addr_pins >= 4'hD) [*5] |-> data_pins_out == 8'h00)
    else $error("unmapped address read not zero");
  irq_level_a: assert property (irq_n_oe |-> irq_n_out == 1'b0)
    else $error("interrupt line not pulled low");
  flag_hold_a: assert property ($fell(irq_n_oe) |-> wr_age <= 8'd12)
    else $error("interrupt released without a write");
endmodule
bind elapsed_time_counter etc_monitor mon (.clk_sys(clk_sys), .nrst(nrst), .osc_in(osc_in),
  .on_battery(on_battery), .power_fail(power_fail), .event_input(event_input), .ce_n(ce_n),
  .oe_n(oe_n), .we_n(we_n), .addr_pins(addr_pins), .data_pins_in(data_pins_in),
  .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .irq_n_out(irq_n_out),
  .irq_n_oe(irq_n_oe), .square_out(square_out), .square_oe(square_oe));
